// >>> logic/bkc_pkg.sv
`default_nettype none
package bkc_pkg;
   localparam int unsigned NUM_WORDS = 16;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned WORD_W = 9;
   localparam int unsigned CNT_W = 6;
   // control word layout
   localparam int unsigned W_CNT_LSB = 0;
   localparam int unsigned W_LAST_OSC = 6;
   localparam int unsigned W_CORR = 7;
   localparam int unsigned W_PAR = 8;
   localparam logic [5:0] CNT_RELOAD = 6'h20;
   localparam logic [5:0] CNT_ADD_Q0 = 6'h05;
   localparam logic [5:0] CNT_ADD_Q1 = 6'h03;
   localparam logic [5:0] CNT_SUB_Q2 = 6'h02;
   localparam logic [5:0] CNT_SUB_Q3 = 6'h04;
   // register map, byte offsets
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_STROBES = 4'h8;
   localparam logic [3:0] REG_LAST = 4'hC;
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned CTRL_PCHK = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int unsigned ST_PERR = 0;
   localparam int unsigned ST_PERR_ADR = 4;

   typedef enum logic [1:0] {
      PH_INIT,
      PH_IDLE,
      PH_READ,
      PH_HOLD
   } bkc_phase_e;

   // status lines of the selected line interface
   typedef struct packed {
      logic sync_line_indication;
      logic modem_clock_indication;
      logic [1:0] osc_select;
      logic rx_line_transition_compare;
      logic rx_clock_shift_indication;
   } bkc_line_s;
endpackage
`default_nettype wire

// >>> logic/bkc_word_store.sv
`default_nettype none
module bkc_word_store (
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [8:0] wr_data,
   input wire logic [3:0] rd_addr,
   output logic [8:0] rd_data
);
   logic [8:0] mem [0:15];
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// >>> logic/bkc_bit_clock_control.sv
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`default_nettype none
module bkc_bit_clock_control (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [3:0] sel_lines,
   input wire logic read_gate,
   input wire logic write_gate,
   input wire bkc_pkg::bkc_line_s line_status,
   input wire logic [3:0] rx_osc,
   output logic bit_strobe,
   output logic [3:0] bit_strobe_addr,
   output logic clock_shift_reset,
   output logic parity_error,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef struct packed {
      bkc_pkg::bkc_phase_e phase;
      logic [3:0] addr;
      logic [3:0] init_addr;
      logic present_osc_sample;
      bkc_pkg::bkc_line_s line;
      logic [8:0] new_word;
      logic strobe_pend;
      logic shift_pend;
      logic strobe;
      logic [3:0] strobe_addr;
      logic shift_rst;
      logic [1:0] ctrl;
      logic perr;
      logic [3:0] perr_addr;
      logic [15:0] strobes;
      logic [3:0] last_addr;
      logic [8:0] last_word;
      logic wait_n;
      logic [31:0] rdata;
      logic [3:0] osc_s1;
      logic [3:0] osc_s2;
      logic [3:0] osc_s3;
      logic [3:0] osc_f;
   } bkc_state_s;

   bkc_state_s st_ff;
   bkc_state_s nxt_st;
   logic [8:0] rd_word;
   logic mem_we;
   logic [3:0] mem_waddr;
   logic [8:0] mem_wdata;
   logic [3:0] osc_filt;

   // oscillators run free of sys_clk: a change counts once flops two and three agree
   for (genvar gi = 0; gi < 4; gi++) begin : g_osc_sync
      assign osc_filt[gi] = (st_ff.osc_s2[gi] == st_ff.osc_s3[gi]) ?
         st_ff.osc_s3[gi] : st_ff.osc_f[gi];
   end

   function automatic logic [8:0] with_parity(input logic [7:0] body);
      with_parity = {~^body, body};
   endfunction

   bkc_word_store u_store (
      .sys_clk(sys_clk),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(sel_lines),
      .rd_data(rd_word)
   );

   always_comb begin
      logic [5:0] cnt;
      logic last_osc;
      logic corr;
      logic strobe_now;
      logic shift_now;
      logic perr_set;
      cnt = rd_word[5:0];
      last_osc = rd_word[bkc_pkg::W_LAST_OSC];
      corr = rd_word[bkc_pkg::W_CORR];
      strobe_now = 1'b0;
      shift_now = 1'b0;
      perr_set = 1'b0;
      nxt_st = st_ff;
      nxt_st.osc_s1 = rx_osc;
      nxt_st.osc_s2 = st_ff.osc_s1;
      nxt_st.osc_s3 = st_ff.osc_s2;
      // filtered level lags the pin by four edges
      nxt_st.osc_f = osc_filt;
      mem_we = 1'b0;
      mem_waddr = st_ff.addr;
      mem_wdata = st_ff.new_word;
      nxt_st.shift_rst = 1'b0;

      unique case (st_ff.phase)
         bkc_pkg::PH_INIT: begin
            // store has no reset; seed every word with a clean parity
            mem_we = 1'b1;
            mem_waddr = st_ff.init_addr;
            mem_wdata = with_parity({2'b00, bkc_pkg::CNT_RELOAD});
            nxt_st.init_addr = st_ff.init_addr + 4'h1;
            if (st_ff.init_addr == 4'hF) begin
               nxt_st.phase = bkc_pkg::PH_IDLE;
            end
         end
         bkc_pkg::PH_IDLE: begin
            if (read_gate) begin
               nxt_st.addr = sel_lines;
               nxt_st.line = line_status;
               nxt_st.present_osc_sample = st_ff.osc_f[line_status.osc_select];
               nxt_st.phase = bkc_pkg::PH_READ;
            end
         end
         bkc_pkg::PH_READ: begin
            // word out of the store is valid now
            if (st_ff.ctrl[bkc_pkg::CTRL_PCHK] && (^rd_word == 1'b0)) begin
               perr_set = 1'b1;
            end
            if (st_ff.ctrl[bkc_pkg::CTRL_EN]) begin
               if (st_ff.line.modem_clock_indication &&
                   st_ff.line.rx_clock_shift_indication) begin
                  cnt = bkc_pkg::CNT_RELOAD;
                  last_osc = st_ff.present_osc_sample;
                  shift_now = 1'b1;
               end else if (st_ff.present_osc_sample != last_osc) begin
                  last_osc = st_ff.present_osc_sample;
                  if (!st_ff.line.modem_clock_indication &&
                      st_ff.line.rx_line_transition_compare && !corr) begin
                     corr = 1'b1;
                     if (st_ff.line.sync_line_indication) begin
                        unique case (cnt[5:4])
                           2'b00: cnt = cnt + bkc_pkg::CNT_ADD_Q0;
                           2'b01: cnt = cnt + bkc_pkg::CNT_ADD_Q1;
                           2'b10: cnt = cnt - bkc_pkg::CNT_SUB_Q2;
                           2'b11: cnt = cnt - bkc_pkg::CNT_SUB_Q3;
                        endcase
                     end else begin
                        cnt = bkc_pkg::CNT_RELOAD;
                     end
                  end else begin
                     // modem clock, flag set or no transition: step by one only
                     cnt = cnt + 6'h01;
                     if (cnt == 6'h00) begin
                        strobe_now = 1'b1;
                        corr = 1'b0;
                     end
                  end
               end
               // equal samples fall through with the word unchanged
            end
            nxt_st.new_word = with_parity({corr, last_osc, cnt});
            nxt_st.strobe_pend = strobe_now;
            nxt_st.shift_pend = shift_now;
            if (perr_set) begin
               nxt_st.perr_addr = st_ff.addr;
            end
            nxt_st.phase = bkc_pkg::PH_HOLD;
         end
         bkc_pkg::PH_HOLD: begin
            if (write_gate) begin
               mem_we = 1'b1;
               // strobe held until the next write gate, one select cycle
               nxt_st.strobe = st_ff.strobe_pend;
               nxt_st.strobe_addr = st_ff.addr;
               nxt_st.shift_rst = st_ff.shift_pend;
               nxt_st.last_addr = st_ff.addr;
               nxt_st.last_word = st_ff.new_word;
               if (st_ff.strobe_pend) begin
                  nxt_st.strobes = st_ff.strobes + 16'h0001;
               end
               nxt_st.phase = bkc_pkg::PH_IDLE;
            end else if (read_gate) begin
               // missed write gate: drop the update, take the new select
               nxt_st.addr = sel_lines;
               nxt_st.line = line_status;
               nxt_st.present_osc_sample = st_ff.osc_f[line_status.osc_select];
               nxt_st.phase = bkc_pkg::PH_READ;
            end
         end
      endcase

      // register slave: one wait cycle, answer on the second edge
      if ((avs_read || avs_write) && st_ff.wait_n) begin
         nxt_st.wait_n = 1'b0;
         unique case (avs_address)
            bkc_pkg::REG_STATUS: begin
               nxt_st.rdata = {24'h000000, st_ff.perr_addr, 3'h0, st_ff.perr};
            end
            bkc_pkg::REG_CTRL: begin
               nxt_st.rdata = {30'h00000000, st_ff.ctrl};
            end
            bkc_pkg::REG_STROBES: begin
               nxt_st.rdata = {16'h0000, st_ff.strobes};
            end
            bkc_pkg::REG_LAST: begin
               nxt_st.rdata = {19'h00000, st_ff.last_addr, st_ff.last_word};
            end
            default: begin
               nxt_st.rdata = 32'h00000000;
            end
         endcase
      end else if (!st_ff.wait_n) begin
         nxt_st.wait_n = 1'b1;
         if (avs_write) begin
            if (avs_address == bkc_pkg::REG_CTRL) begin
               nxt_st.ctrl = avs_writedata[1:0];
            end
            if ((avs_address == bkc_pkg::REG_STATUS) &&
                avs_writedata[bkc_pkg::ST_PERR]) begin
               nxt_st.perr = 1'b0;
            end
            if (avs_address == bkc_pkg::REG_STROBES) begin
               nxt_st.strobes = 16'h0000;
            end
         end
      end
      // a new error wins over a clear in the same cycle
      if (perr_set) begin
         nxt_st.perr = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.phase <= bkc_pkg::PH_INIT;
         st_ff.ctrl <= bkc_pkg::CTRL_RESET;
         st_ff.wait_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bit_strobe = st_ff.strobe;
   assign bit_strobe_addr = st_ff.strobe_addr;
   assign clock_shift_reset = st_ff.shift_rst;
   assign parity_error = st_ff.perr;
   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.wait_n;
endmodule
`default_nettype wire

// >>> sim/bkc_checker_assertions.sv
`default_nettype none
module bkc_checker (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [3:0] sel_lines,
   input wire logic write_gate,
   input wire bkc_pkg::bkc_line_s line_status,
   input wire logic bit_strobe,
   input wire logic [3:0] bit_strobe_addr,
   input wire logic clock_shift_reset,
   input wire logic parity_error,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");
   a_bus_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
      else $error("waitrequest low while idle");
   a_strobe_hold: assert property (
      !$past(write_gate) |-> $stable({bit_strobe, bit_strobe_addr})) else $error("strobe moved");
   a_strobe_addr_sel: assert property (
      $past(write_gate) |-> bit_strobe_addr == $past(sel_lines)) else $error("bad strobe addr");
   a_shift_pulse: assert property (clock_shift_reset |=> !clock_shift_reset)
      else $error("shift reset too long");
   a_shift_cause: assert property ($rose(clock_shift_reset) |-> $past(write_gate)
      && $past(line_status.rx_clock_shift_indication && line_status.modem_clock_indication))
      else $error("shift reset without cause");
   a_forced_no_strobe: assert property (clock_shift_reset |-> !bit_strobe)
      else $error("strobe on forced word");
   a_store_clean: assert property (!parity_error)
      else $error("parity error on clean store");
   cover property ($rose(bit_strobe));
   cover property ($rose(clock_shift_reset));
   cover property (avs_read && !avs_waitrequest);
endmodule
bind bkc_bit_clock_control bkc_checker bkc_checker_i (.sys_clk, .resetn, .sel_lines,
   .write_gate, .line_status, .bit_strobe, .bit_strobe_addr, .clock_shift_reset,
   .parity_error, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// >>> sim/bkc_scanner_model.sv
`default_nettype none
module bkc_scanner_model (
   input wire logic sys_clk,
   input wire logic resetn,
   output logic [3:0] sel_lines,
   output logic read_gate,
   output logic write_gate,
   output logic [3:0] rx_osc
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] warm_ff;
   logic [2:0] ph_ff;
   wire logic scan_on = (warm_ff == 5'h18);
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         warm_ff <= 5'h00;
         ph_ff <= 3'h0;
         sel_lines <= 4'hF;
         rx_osc <= 4'h0;
      end else if (!scan_on) begin
         warm_ff <= warm_ff + 5'h01;
      end else begin
         ph_ff <= ph_ff + 3'h1;
         if (ph_ff == 3'h7) sel_lines <= sel_lines + 4'h1;
         // others held still so a wrong select never sees a change
         // toggle after word 15 is read, leaving time for the input synchroniser
         if (ph_ff == 3'h3 && sel_lines == 4'hF) rx_osc[2] <= ~rx_osc[2];
      end
   end
   // eight-cycle slot keeps the run short; write four cycles after read
   assign read_gate = scan_on && ph_ff == 3'h1;
   assign write_gate = scan_on && ph_ff == 3'h5;
endmodule
`default_nettype wire

// >>> sim/tb_bkc_bit_clock_control.sv
`default_nettype none
module tb_bkc_bit_clock_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, resetn, read_gate, write_gate, bit_strobe, clock_shift_reset, parity_error;
   logic avs_read, avs_write, avs_waitrequest, wg_d;
   logic [3:0] sel_lines, rx_osc, bit_strobe_addr, avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   bkc_pkg::bkc_line_s line_status;
   int failures, n_checks, exp_strb, seen;
   int p_tab[4] = '{1, 17, 33, 49};
   int adj_tab[4] = '{5, 3, -2, -4};
   bkc_bit_clock_control bkc_bit_clock_control_i (.sys_clk, .resetn, .sel_lines, .read_gate,
      .write_gate, .line_status, .rx_osc, .bit_strobe, .bit_strobe_addr, .clock_shift_reset,
      .parity_error, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest);
   bkc_scanner_model bkc_scanner_model_i (.sys_clk, .resetn, .sel_lines, .read_gate,
      .write_gate, .rx_osc);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      wg_d <= write_gate;
      if (wg_d === 1'b1 && bit_strobe === 1'b1) seen <= seen + 1;
   end
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic guard(input int t);
      if (t >= 300) begin
         failures++;
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] adr);
      int t;
      t = 0;
      avs_address <= adr;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge sys_clk);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 300);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
      guard(t);
   endtask
   // one round = all sixteen words, ended at the write of word 15
   task automatic run(input bkc_pkg::bkc_line_s st, input int n, input int add);
      int t;
      line_status <= st;
      repeat (n) begin
         t = 0;
         do begin
            @(posedge sys_clk);
            t++;
         end while (!(sel_lines === 4'hF && write_gate === 1'b1) && t < 300);
         guard(t);
      end
      repeat (3) @(posedge sys_clk);
      exp_strb += add;
      check(seen, exp_strb);
   endtask
   function automatic bkc_pkg::bkc_line_s ls(input logic sy, md, cmp, sh);
      return '{sy, md, 2'h2, cmp, sh};
   endfunction
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h00000000;
      line_status = '0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      check({avs_waitrequest, bit_strobe, parity_error, clock_shift_reset}, 4'h8);
      run(ls(0, 0, 0, 0), 1, 0);
      run(ls(0, 0, 1, 0), 1, 0);
      run(ls(0, 0, 1, 0), 31, 0);
      run(ls(0, 0, 1, 0), 1, 16);
      for (int q = 0; q < 4; q++) begin
         run(ls(1, 0, 0, 0), p_tab[q], 0);
         run(ls(1, 0, 1, 0), 1, 0);
         run(ls(1, 0, 1, 0), 63 - p_tab[q] - adj_tab[q], 0);
         run(ls(1, 0, 1, 0), 1, 16);
      end
      run(ls(1, 1, 0, 1), 1, 0);
      run(ls(1, 1, 1, 0), 31, 0);
      run(ls(1, 1, 1, 0), 1, 16);
      bus(1'b0, bkc_pkg::REG_STROBES);
      check(rd, exp_strb);
      bus(1'b0, bkc_pkg::REG_CTRL);
      check(rd, 32'h00000003);
      bus(1'b0, bkc_pkg::REG_STATUS);
      check(rd, 32'h00000000);
      bus(1'b0, bkc_pkg::REG_LAST);
      check({31'h00000000, ^rd[8:0]}, 32'h00000001);
      bus(1'b1, bkc_pkg::REG_STROBES);
      bus(1'b0, bkc_pkg::REG_STROBES);
      check(rd, 32'h00000000);
      avs_writedata <= 32'h00000002;
      bus(1'b1, bkc_pkg::REG_CTRL);
      bus(1'b0, bkc_pkg::REG_CTRL);
      check(rd, 32'h00000002);
      run(ls(0, 0, 0, 0), 64, 0);
      bus(1'b0, bkc_pkg::REG_STROBES);
      check(rd, 32'h00000000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
